// ===== rtl/bar_control.sv
// Summary of operation
// - Fixed 20 ms blanking before burst or restart
// - After blanking, release clamp; wait high level
// - Extra 30 us spike filter before restart
// - Burst uses only internal blanking
// - Burst after 20 ms continuous low feedback
// - Burst entry sets flag, bias off
// - Startup cell off throughout burst
// - Feedback above wake level: bias on, switch
// - Reduced current limit while in burst
// - Feedback at sleep level: bias off again
// - Feedback high in burst leaves burst
// - Only overload uses blanking; others immediate, except 120 us overvoltage hold and 30 us external request filter
// - Restart: stop, recharge, soft start, recheck
// - High feedback in normal mode starts overload blanking
// - Soft start overvoltage with high feedback restarts
// - Supply overvoltage held 120 us restarts
// - Overvoltage check disabled during burst
// - Overtemperature enters auto restart
// - External pin request stops gate, restarts
// - External request ignored 1 ms after start
// - Undervoltage switches off, enables startup cell
// - Soft start reruns at every restart attempt
//
// Design decisions made here: the register offsets and the APB slave port.
`include "bar_consts.svh"
`default_nettype none

module bar_control #(
  parameter int          CW          = 24,
  parameter logic [23:0] BLANK_CYC   = 24'(`BAR_US_TO_CYC(`BAR_BLANK_US)),
  parameter logic [23:0] SPIKE_CYC   = 24'(`BAR_US_TO_CYC(`BAR_SPIKE_US)),
  parameter logic [23:0] VCC_OV_CYC  = 24'(`BAR_US_TO_CYC(`BAR_VCC_OV_US)),
  parameter logic [23:0] EXT_DLY_CYC = 24'(`BAR_US_TO_CYC(`BAR_EXT_DELAY_US)),
  parameter logic [23:0] SS_CYC      = 24'(`BAR_US_TO_CYC(`BAR_SOFTSTART_US))
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        fb_below_low,
  input  wire logic        fb_above_wake,
  input  wire logic        fb_below_sleep,
  input  wire logic        fb_above_high,
  input  wire logic        vcc_above_ss_ov,
  input  wire logic        vcc_above_ov,
  input  wire logic        temp_above_limit,
  input  wire logic        ba_above_high,
  input  wire logic        ba_below_ext,
  input  wire logic        vcc_below_off,
  input  wire logic        vcc_above_on,
  output var  logic        bias_en,
  output var  logic        startup_cell_en,
  output var  logic        reduced_limit_en,
  output var  logic        gate_en,
  output var  logic        ba_clamp_en,
  output var  logic        soft_start_active,
  output var  logic        burst_flag
);
  import bar_pkg::*;

  localparam int NIN = 11;
  localparam int NT  = 7;
  // Timer indices
  localparam int T_BURST = 0;
  localparam int T_OVL   = 1;
  localparam int T_SPIKE = 2;
  localparam int T_OV    = 3;
  localparam int T_EXTD  = 4;
  localparam int T_EXTP  = 5;
  localparam int T_SS    = 6;

  bar_state_type state;
  bar_state_type next_state;

  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1;
  logic [NIN-1:0] s2;
  logic [NIN-1:0] s3;
  logic [NIN-1:0] sv;
  logic [CW-1:0]  cnt [NT];
  logic [CW-1:0]  lim [NT];
  logic [NT-1:0]  qual;
  logic [NT-1:0]  done;
  logic [1:0]     ctrl;
  logic [`BAR_CA_WIDTH-1:0] cause;
  logic [`BAR_CA_WIDTH-1:0] next_cause;
  logic fb_low;
  logic fb_wake;
  logic fb_sleep;
  logic fb_high;
  logic vcc_ss_ov;
  logic vcc_ov;
  logic over_temp;
  logic ba_high;
  logic ba_ext;
  logic vcc_off;
  logic vcc_on;
  logic ic_on;
  logic ext_stop;
  logic clamp_open;
  logic restart_and_gate;
  logic fast_fault;
  logic any_fault;
  logic apb_access;
  logic apb_commit;

  assign raw_in = {vcc_above_on, vcc_below_off, ba_below_ext, ba_above_high, temp_above_limit,
                   vcc_above_ov, vcc_above_ss_ov, fb_above_high, fb_below_sleep, fb_above_wake,
                   fb_below_low};

  // three-stage input filter
  // A level is accepted only when stages two and three agree, so a glitch is not seen
  for (genvar gi = 0; gi < NIN; gi++) begin : g_sync
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        s1[gi] <= 1'b0;
        s2[gi] <= 1'b0;
        s3[gi] <= 1'b0;
        sv[gi] <= 1'b0;
      end else begin
        s1[gi] <= raw_in[gi];
        s2[gi] <= s1[gi];
        s3[gi] <= s2[gi];
        if (s2[gi] == s3[gi]) begin
          sv[gi] <= s3[gi];
        end
      end
    end
  end

  assign fb_low    = sv[0];
  assign fb_wake   = sv[1];
  assign fb_sleep  = sv[2];
  assign fb_high   = sv[3];
  assign vcc_ss_ov = sv[4];
  assign vcc_ov    = sv[5];
  assign over_temp = sv[6];
  assign ba_high   = sv[7];
  assign ba_ext    = sv[8];
  assign vcc_off   = sv[9];
  assign vcc_on    = sv[10];

  // The controller is powered and may switch in these states
  assign ic_on = (state == ST_SOFTSTART) || (state == ST_NORMAL) ||
                 (state == ST_BURST_OFF) || (state == ST_BURST_ON);

  // Interval limits and the conditions that let each timer run
  always_comb begin
    lim[T_BURST] = BLANK_CYC;
    lim[T_OVL]   = BLANK_CYC;
    lim[T_SPIKE] = SPIKE_CYC;
    lim[T_OV]    = VCC_OV_CYC;
    lim[T_EXTD]  = EXT_DLY_CYC;
    lim[T_EXTP]  = SPIKE_CYC;
    lim[T_SS]    = SS_CYC;
    // burst timer is internal blanking only
    qual[T_BURST] = (state == ST_NORMAL) && fb_low && ctrl[`BAR_CTRL_BURST_BIT];
    qual[T_OVL]   = (state == ST_NORMAL) && fb_high;
    qual[T_SPIKE] = restart_and_gate;
    qual[T_OV]    = ic_on && !burst_flag && vcc_ov;
    qual[T_EXTD]  = ic_on;
    qual[T_EXTP]  = ext_stop;
    qual[T_SS]    = (state == ST_SOFTSTART);
  end

  for (genvar ti = 0; ti < NT; ti++) begin : g_tmr
    assign done[ti] = qual[ti] && (cnt[ti] == lim[ti]);
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        cnt[ti] <= '0;
      end else if (!qual[ti]) begin
        cnt[ti] <= '0;
      end else if (!done[ti]) begin
        cnt[ti] <= cnt[ti] + 1'b1;
      end
    end
  end

  // clamp opens only after internal blanking
  // Left open while the overload persists; closes again as soon as feedback recovers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clamp_open <= 1'b0;
    end else begin
      clamp_open <= done[T_OVL];
    end
  end

  assign restart_and_gate = clamp_open && ba_high && fb_high && (state == ST_NORMAL);

  assign ext_stop = ba_ext && done[T_EXTD] && ctrl[`BAR_CTRL_EXT_BIT];

  // Fault sources, grouped by whether they skip the blanking
  always_comb begin
    next_cause = '0;
    next_cause[`BAR_CA_SS_OV]    = (state == ST_SOFTSTART) && vcc_ss_ov && fb_high;
    next_cause[`BAR_CA_VCC_OV]   = done[T_OV];
    next_cause[`BAR_CA_TEMP]     = ic_on && over_temp;
    next_cause[`BAR_CA_UVLO]     = ic_on && vcc_off;
    next_cause[`BAR_CA_EXT]      = done[T_EXTP];
    next_cause[`BAR_CA_OVERLOAD] = done[T_SPIKE];
  end

  assign fast_fault = |next_cause[`BAR_CA_EXT:`BAR_CA_SS_OV];
  assign any_fault  = fast_fault || next_cause[`BAR_CA_OVERLOAD];

  // Mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_CHARGE: begin
        if (vcc_on) begin
          next_state = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART: begin
        if (any_fault) begin
          next_state = ST_RESTART;
        end else if (done[T_SS]) begin
          next_state = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (any_fault) begin
          next_state = ST_RESTART;
        end else if (done[T_BURST] && fb_low) begin
          next_state = ST_BURST_OFF;
        end
      end
      ST_BURST_OFF: begin
        if (any_fault) begin
          next_state = ST_RESTART;
        end else if (fb_high) begin
          next_state = ST_NORMAL;
        end else if (fb_wake) begin
          next_state = ST_BURST_ON;
        end
      end
      ST_BURST_ON: begin
        if (any_fault) begin
          next_state = ST_RESTART;
        end else if (fb_high) begin
          next_state = ST_NORMAL;
        end else if (fb_sleep) begin
          next_state = ST_BURST_OFF;
        end
      end
      ST_RESTART: begin
        if (vcc_off) begin
          next_state = ST_CHARGE;
        end
      end
      default: begin
        next_state = ST_CHARGE;
      end
    endcase
  end

  // State register; power-up begins by charging the supply
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_CHARGE;
    end else begin
      state <= next_state;
    end
  end

  // Outputs except ba_clamp_en decoded from the next state so they line up with the state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bias_en           <= 1'b0;
      startup_cell_en   <= 1'b1;
      reduced_limit_en  <= 1'b0;
      gate_en           <= 1'b0;
      ba_clamp_en       <= 1'b1;
      soft_start_active <= 1'b0;
      burst_flag        <= 1'b0;
    end else begin
      bias_en           <= (next_state == ST_SOFTSTART) || (next_state == ST_NORMAL) ||
                           (next_state == ST_BURST_ON);
      startup_cell_en   <= (next_state == ST_CHARGE);
      reduced_limit_en  <= (next_state == ST_BURST_OFF) || (next_state == ST_BURST_ON);
      // gate stopped at once by request
      gate_en           <= ((next_state == ST_SOFTSTART) || (next_state == ST_NORMAL) ||
                            (next_state == ST_BURST_ON)) && !ext_stop;
      ba_clamp_en       <= !done[T_OVL];
      soft_start_active <= (next_state == ST_SOFTSTART);
      burst_flag        <= (next_state == ST_BURST_OFF) || (next_state == ST_BURST_ON);
    end
  end

  // APB: one wait state, data and error registered in the first access cycle
  assign apb_access = psel && penable && !pready;
  assign apb_commit = psel && penable && pready;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      if (apb_access) begin
        pslverr <= !(paddr == `BAR_CTRL_OFS || paddr == `BAR_STATUS_OFS || paddr == `BAR_CAUSE_OFS);
        prdata  <= 32'h0;
        if (!pwrite) begin
          case (paddr)
            `BAR_CTRL_OFS: begin
              prdata <= {30'h0, ctrl};
            end
            `BAR_STATUS_OFS: begin
              prdata <= {13'h0, sv, bias_en, startup_cell_en, gate_en, !ba_clamp_en, burst_flag, state};
            end
            `BAR_CAUSE_OFS: begin
              prdata <= {26'h0, cause};
            end
            default: begin
              prdata <= 32'h0;
            end
          endcase
        end
      end else if (!pready) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register; burst entry and external request can be masked by software
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `BAR_CTRL_RESET;
    end else if (apb_commit && pwrite && paddr == `BAR_CTRL_OFS) begin
      ctrl <= pwdata[1:0];
    end
  end

  // Sticky fault causes, write one to clear; a new fault wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause <= '0;
    end else begin
      if (apb_commit && pwrite && paddr == `BAR_CAUSE_OFS) begin
        cause <= (cause & ~pwdata[`BAR_CA_WIDTH-1:0]) |
                 (next_state == ST_RESTART && state != ST_RESTART ? next_cause : '0);
      end else if (next_state == ST_RESTART && state != ST_RESTART) begin
        cause <= cause | next_cause;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_burst_entry_blank: assert property (
    $rose(burst_flag) |-> $past(cnt[T_BURST]) == BLANK_CYC && $past(fb_low))
    else $error("burst entered without full blanking");

  a_burst_bias_off: assert property (
    state == ST_BURST_OFF |-> !bias_en && burst_flag && reduced_limit_en)
    else $error("bias on while burst sleeps");

  a_burst_cell_off: assert property (
    burst_flag |-> !startup_cell_en)
    else $error("startup cell on in burst");

  a_burst_wake: assert property (
    state == ST_BURST_OFF && fb_wake && !fb_high && !any_fault |=> bias_en && (gate_en == !$past(ext_stop)))
    else $error("no wake on high feedback");

  a_burst_sleep: assert property (
    state == ST_BURST_ON && fb_sleep && !fb_high && !any_fault |=> !bias_en && !gate_en)
    else $error("no sleep on low feedback");

  a_burst_exit: assert property (
    burst_flag && fb_high && !any_fault && (state == ST_BURST_ON || state == ST_BURST_OFF)
      |=> !reduced_limit_en && state == ST_NORMAL)
    else $error("burst not left on high feedback");

  a_clamp_release: assert property (
    state == ST_NORMAL && fb_high && cnt[T_OVL] == BLANK_CYC |=> !ba_clamp_en)
    else $error("clamp kept after overload blanking");

  a_spike_filter: assert property (
    $rose(restart_and_gate) |-> (!next_cause[`BAR_CA_OVERLOAD]) [*2])
    else $error("overload restart without spike filter");

  a_ov_burst_off: assert property (
    burst_flag && $past(burst_flag) |-> cnt[T_OV] == '0)
    else $error("overvoltage timer running in burst");

  a_uvlo_restart: assert property (
    state == ST_NORMAL && vcc_off |=> state == ST_RESTART ##1 startup_cell_en)
    else $error("undervoltage did not restart");

  a_ext_blank: assert property (
    state == ST_CHARGE ##1 state == ST_SOFTSTART |-> !ext_stop [*8])
    else $error("external request seen inside start delay");

endmodule : bar_control

`default_nettype wire

// ===== rtl/bar_consts.svh
`ifndef BAR_CONSTS_SVH
`define BAR_CONSTS_SVH

// Clock rate in MHz; all intervals are whole microseconds, so counts are exact
`define BAR_CLK_MHZ         20
`define BAR_US_TO_CYC(t)    ((t) * `BAR_CLK_MHZ)

// Intervals as printed, in microseconds
`define BAR_BLANK_US        20000
`define BAR_SPIKE_US        30
`define BAR_VCC_OV_US       120
`define BAR_EXT_DELAY_US    1000
`define BAR_SOFTSTART_US    20000

// Register offsets (byte addresses)
`define BAR_CTRL_OFS        8'h00
`define BAR_STATUS_OFS      8'h04
`define BAR_CAUSE_OFS       8'h08

// Control field positions and reset value
`define BAR_CTRL_BURST_BIT  0
`define BAR_CTRL_EXT_BIT    1
`define BAR_CTRL_RESET      2'h3

// Status field positions
`define BAR_ST_STATE_LSB    0
`define BAR_ST_BURST_BIT    3
`define BAR_ST_CLAMP_BIT    4
`define BAR_ST_GATE_BIT     5
`define BAR_ST_CELL_BIT     6
`define BAR_ST_BIAS_BIT     7
`define BAR_ST_CMP_LSB      8

// Fault cause bit positions
`define BAR_CA_OVERLOAD     0
`define BAR_CA_SS_OV        1
`define BAR_CA_VCC_OV       2
`define BAR_CA_TEMP         3
`define BAR_CA_UVLO         4
`define BAR_CA_EXT          5
`define BAR_CA_WIDTH        6

`endif

// ===== rtl/bar_pkg.sv
`default_nettype none

package bar_pkg;

  // Gray coded along charge, soft start, normal, burst off, burst on, restart
  typedef enum logic [2:0] {
    ST_CHARGE    = 3'h0,
    ST_SOFTSTART = 3'h1,
    ST_NORMAL    = 3'h3,
    ST_BURST_OFF = 3'h2,
    ST_BURST_ON  = 3'h6,
    ST_RESTART   = 3'h7
  } bar_state_type;

endpackage : bar_pkg

`default_nettype wire

// ===== testbench/bar_far_side.sv
`default_nettype none

// Feedback network, supply capacitor and blanking pin seen from the outside
module bar_far_side #(
  parameter int VON_MV  = 15000,
  parameter int BA_STEP = 155
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] fb_mv,
  input  wire logic [15:0] vcc_set_mv,
  input  wire logic        ext_pull,
  input  wire logic        gate_en,
  input  wire logic        bias_en,
  input  wire logic        burst_flag,
  input  wire logic        startup_cell_en,
  input  wire logic        ba_clamp_en,
  output wire logic        fb_below_low,
  output wire logic        fb_above_wake,
  output wire logic        fb_below_sleep,
  output wire logic        fb_above_high,
  output wire logic        vcc_above_ss_ov,
  output wire logic        vcc_above_ov,
  output wire logic        ba_above_high,
  output wire logic        ba_below_ext,
  output wire logic        vcc_below_off,
  output wire logic        vcc_above_on
);
  timeunit 1ns;
  timeprecision 1ps;
  int vcc;
  int ba;

  // Cell charges the capacitor; an idle part drains it, else it is regulated
  always @(posedge sys_clk or posedge rst) begin
    if (rst) vcc <= 0;
    else if (startup_cell_en) vcc <= vcc + 1000;
    else if (!gate_en && !bias_en && !burst_flag) vcc <= vcc - 500;
    else vcc <= int'(vcc_set_mv);
  end

  // external pull-down wins over clamp and charge current
  always @(posedge sys_clk or posedge rst) begin
    if (rst) ba <= 900;
    else if (ext_pull) ba <= 100;
    else if (ba_clamp_en) ba <= 900;
    else if (ba < 5000) ba <= ba + BA_STEP;
  end

  // Comparator levels in millivolts
  assign fb_below_low    = fb_mv < 16'd1350;
  assign fb_above_wake   = fb_mv > 16'd3500;
  assign fb_below_sleep  = fb_mv <= 16'd3050;
  assign fb_above_high   = fb_mv > 16'd4000;
  assign vcc_above_ss_ov = vcc > 20500;
  assign vcc_above_ov    = vcc > 25500;
  assign vcc_below_off   = vcc < 10500;
  assign vcc_above_on    = vcc > VON_MV;
  assign ba_above_high   = ba >= 4000;
  assign ba_below_ext    = ba < 330;
endmodule : bar_far_side

`default_nettype wire

// ===== testbench/testbench.sv
`include "bar_consts.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bar_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, ext_pull, temp_hot, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fb_mv, vcc_set_mv;
  logic        pready, pslverr, bias_en, startup_cell_en, reduced_limit_en, gate_en;
  logic        ba_clamp_en, soft_start_active, burst_flag;
  logic        fb_below_low, fb_above_wake, fb_below_sleep, fb_above_high, vcc_above_ss_ov;
  logic        vcc_above_ov, ba_above_high, ba_below_ext, vcc_below_off, vcc_above_on;
  int          n_mismatch, n_checks, n, f;
  integer      seed;
  int          lo[4] = '{2, 12, 2, 2};
  int          hi[4] = '{9, 22, 9, 9};
  int          cb[4] = '{`BAR_CA_TEMP, `BAR_CA_VCC_OV, `BAR_CA_EXT, `BAR_CA_UVLO};

  // Shortened intervals keep the run brief
  bar_control #(.BLANK_CYC(24'h28), .SS_CYC(24'h28), .EXT_DLY_CYC(24'h14), .VCC_OV_CYC(24'hc),
    .SPIKE_CYC(24'h6)) bar_control_i (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fb_below_low, .fb_above_wake, .fb_below_sleep, .fb_above_high,
    .vcc_above_ss_ov, .vcc_above_ov, .temp_above_limit(temp_hot), .ba_above_high, .ba_below_ext,
    .vcc_below_off, .vcc_above_on, .bias_en, .startup_cell_en, .reduced_limit_en, .gate_en,
    .ba_clamp_en, .soft_start_active, .burst_flag);

  bar_far_side bar_far_side_i (.sys_clk, .rst, .fb_mv, .vcc_set_mv, .ext_pull, .gate_en, .bias_en,
    .burst_flag, .startup_cell_en, .ba_clamp_en, .fb_below_low, .fb_above_wake, .fb_below_sleep,
    .fb_above_high, .vcc_above_ss_ov, .vcc_above_ov, .ba_above_high, .ba_below_ext,
    .vcc_below_off, .vcc_above_on);

  // Clock
  always #25 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, takes data at that edge, then idles a cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  function automatic logic sig(input int s);
    case (s)
      0: return burst_flag;
      1: return bias_en;
      2: return gate_en;
      3: return ba_clamp_en;
      4: return soft_start_active;
      default: return startup_cell_en;
    endcase
  endfunction : sig

  // Bounded wait; n counts the edges it took
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    // A wait that runs out is a mismatch
    chk(32'(sig(s)), 32'(v));
  endtask : wt

  task automatic win(input int l, input int h);
    chk(32'(n >= l && n <= h), 32'h1);
  endtask : win

  task automatic recover();
    wt(4, 1'b1, 400);
    wt(4, 1'b0, 100);
  endtask : recover

  // Sticky fault record, then write-one-to-clear
  task automatic cause(input logic [31:0] m);
    apb(1'b0, `BAR_CAUSE_OFS, 32'h0);
    chk(rd, m);
    apb(1'b1, `BAR_CAUSE_OFS, 32'h3f);
    apb(1'b0, `BAR_CAUSE_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask : cause

  task automatic set_fault(input int k, input logic v);
    case (k)
      0: temp_hot <= v;
      1: vcc_set_mv <= v ? 16'd26000 : 16'd18000;
      2: ext_pull <= v;
      default: vcc_set_mv <= v ? 16'd9000 : 16'd18000;
    endcase
  endtask : set_fault

  task automatic results();
    $display("Checks: %0d, mismatches: %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end

  initial begin
    {sys_clk, psel, penable, pwrite, ext_pull, temp_hot} = 6'h0;
    {n_mismatch, n_checks, n} = '0;
    rst = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    fb_mv = 16'd2500;
    vcc_set_mv = 16'd18000;
    seed = 32'hd683;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(32'({startup_cell_en, ba_clamp_en, bias_en, gate_en, burst_flag, reduced_limit_en}), 32'h30);
    // Register reset value, read-write control, unmapped place
    apb(1'b0, `BAR_CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, `BAR_CTRL_OFS, 32'h1);
    apb(1'b0, `BAR_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `BAR_CTRL_OFS, 32'h3);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    // Power-up: early external pull must be ignored
    wt(4, 1'b1, 200);
    chk(32'({gate_en, startup_cell_en}), 32'h2);
    ext_pull <= 1'b1;
    repeat (10) @(posedge sys_clk);
    ext_pull <= 1'b0;
    chk(32'(gate_en), 32'h1);
    wt(4, 1'b0, 100);
    apb(1'b0, `BAR_STATUS_OFS, 32'h0);
    chk(32'(rd[2:0]), 32'(ST_NORMAL));
    // Short dip of feedback restarts the blanking count
    fb_mv <= 16'(100 + ($unsigned($random(seed)) % 1200));
    repeat (30) @(posedge sys_clk);
    fb_mv <= 16'd2500;
    repeat (40) @(posedge sys_clk);
    chk(32'(burst_flag), 32'h0);
    fb_mv <= 16'(100 + ($unsigned($random(seed)) % 1200));
    wt(0, 1'b1, 80);
    win(41, 52);
    chk(32'({bias_en, startup_cell_en, reduced_limit_en}), 32'h1);
    vcc_set_mv <= 16'd26000;
    repeat (40) @(posedge sys_clk);
    chk(32'(burst_flag), 32'h1);
    vcc_set_mv <= 16'd18000;
    fb_mv <= 16'd3600;
    wt(1, 1'b1, 20);
    win(2, 9);
    chk(32'(gate_en), 32'h1);
    fb_mv <= 16'd3000;
    wt(1, 1'b0, 20);
    win(2, 9);
    chk(32'({burst_flag, reduced_limit_en}), 32'h3);
    fb_mv <= 16'd4500;
    wt(0, 1'b0, 20);
    win(2, 9);
    chk(32'(reduced_limit_en), 32'h0);
    // Overload keeps feedback high through both blanking phases
    wt(3, 1'b0, 80);
    win(36, 46);
    chk(32'(gate_en), 32'h1);
    wt(2, 1'b0, 60);
    win(26, 40);
    fb_mv <= 16'd2500;
    wt(5, 1'b1, 80);
    chk(32'(gate_en), 32'h0);
    recover();
    cause(32'h1 << `BAR_CA_OVERLOAD);
    // Faults that skip the extended blanking
    for (f = 0; f < 4; f++) begin
      set_fault(f, 1'b1);
      wt(2, 1'b0, 40);
      win(lo[f], hi[f]);
      repeat (12) @(posedge sys_clk);
      set_fault(f, 1'b0);
      wt(5, 1'b1, 80);
      chk(32'(n < 80), 32'h1);
      recover();
      cause(32'h1 << cb[f]);
    end
    // Brief overvoltage is filtered out
    set_fault(1, 1'b1);
    repeat (8) @(posedge sys_clk);
    set_fault(1, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk(32'(gate_en), 32'h1);
    // Masked controls: low feedback gives no burst, pin request is ignored
    apb(1'b1, `BAR_CTRL_OFS, 32'h0);
    ext_pull <= 1'b1;
    fb_mv <= 16'd500;
    repeat (60) @(posedge sys_clk);
    chk(32'({gate_en, burst_flag}), 32'h2);
    ext_pull <= 1'b0;
    fb_mv <= 16'd2500;
    repeat (8) @(posedge sys_clk);
    apb(1'b1, `BAR_CTRL_OFS, 32'h3);
    // Overvoltage with high feedback during soft start
    temp_hot <= 1'b1;
    wt(2, 1'b0, 40);
    temp_hot <= 1'b0;
    wt(4, 1'b1, 400);
    vcc_set_mv <= 16'd21000;
    fb_mv <= 16'd4500;
    wt(2, 1'b0, 20);
    win(2, 9);
    vcc_set_mv <= 16'd18000;
    fb_mv <= 16'd2500;
    recover();
    cause((32'h1 << `BAR_CA_TEMP) | (32'h1 << `BAR_CA_SS_OV));
    results();
  end
endmodule : testbench

`default_nettype wire
